// ===== src/vintu_pkg.sv
/*
 package for the vectored interrupt unit: register offsets, vectors,
 stack geometry, sensitivity codes, sequencer states and the state record.
 assumes an 8-bit core with a 64-byte stack and 16-bit addresses.
*/
package vintu_pkg;
    // own register offsets on the plain register port
    localparam logic [2:0] A_SENS  = 3'h0;
    localparam logic [2:0] A_PEN   = 3'h1;
    localparam logic [2:0] A_PFLAG = 3'h2;
    localparam logic [2:0] A_PACK  = 3'h3;
    localparam logic [2:0] A_EPEND = 3'h4;
    // reset values
    localparam logic [7:0] SENS_RST = 8'h00;
    localparam logic [5:0] PEN_RST  = 6'h00;
    // vectors: top two words, then maskable ones descending by two
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_TRAP  = 16'hFFFC;
    localparam logic [15:0] VEC_BASE  = 16'hFFFA;
    // stack lives in 00C0h..00FFh, upper ten bits forced
    localparam logic [15:0] STACK_BASE = 16'h00C0;
    localparam logic [15:0] SP_RESET   = 16'h00FF;
    localparam logic [2:0]  CTX_LAST   = 3'h4;
    localparam logic [5:0]  CTX_BYTES  = 6'h05;
    localparam int          IBIT       = 3;
    localparam int          NVEC       = 12;
    // vector numbers allowed to end halt: 1,2,3,4,9,11,12
    localparam logic [12:0] HALT_WAKE = 13'h1A1E;
    // per-line sensitivity codes
    localparam logic [1:0] S_LOWFALL = 2'h0;
    localparam logic [1:0] S_RISE    = 2'h1;
    localparam logic [1:0] S_FALL    = 2'h2;
    localparam logic [1:0] S_BOTH    = 2'h3;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'h0,
        SEQ_PUSH = 3'h1,
        SEQ_VHI  = 3'h3,
        SEQ_VLO  = 3'h2,
        SEQ_LDPC = 3'h6,
        SEQ_POP  = 3'h4,
        SEQ_POPL = 3'h5
    } vintu_state_type;

    typedef struct packed {
        vintu_state_type st;
        logic [2:0]      cnt;
        logic            mask;
        logic            rst_pend;
        logic            trap_pend;
        logic [3:0]      vec_n;
        logic [15:0]     vaddr;
        logic [15:0]     sp;
        logic [15:0]     pc;
        logic [7:0]      x;
        logic [7:0]      a;
        logic [7:0]      cond;
        logic [7:0]      sens;
        logic [5:0]      pen;
        logic [5:0]      pflag;
        logic [5:0]      parm;
        logic [3:0]      edge_l;
        logic [3:0]      pin_d;
        logic [7:0]      rdata;
        logic            pc_ld;
        logic            ctx_ld;
        logic            wake;
    } vintu_regs_type;
endpackage

// ===== src/vintu_top.sv
/*
 vectored interrupt unit: external line latches, peripheral flags,
 priority, context stacking/unstacking, vector fetch and wake-up.
 assumes the core pulses instr_boundary between instructions, stalls
 while core_hold is high, and memory read data arrive one cycle later.
*/
// What this block does
// - mask set holds maskable requests pending
// - reset leaves the global mask set
// - entry only at an instruction boundary
// - push pc, index, accumulator, condition codes
// - entry sets the global mask
// - load pc from the vector, then fetch
// - return pops context and clears mask
// - fixed priority: reset, trap, ascending vector
// - any request ends wait mode
// - only listed sources end halt mode
// - trap ignores the global mask
// - line vector needs event and clear mask
// - edge latch cleared on handler entry
// - low combined pin masks that line
// - flag needs enable and clear mask
// - clear by writing zero or sequence
// - clearing sequence discards pending request
// - reset and trap vectors at top
// - maskable vectors descend two bytes each
// - five stack bytes, low pc byte first
// - clearing mask in handler serves pending
// - sensitivity codes; code change clears pending
module vintu_top (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // register port
    input  wire logic [2:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // event sources
    input  wire logic [3:0]  ext_line,
    input  wire logic [3:0]  ext_nand_low,
    input  wire logic [5:0]  periph_evt,
    // core sequencer
    input  wire logic        instr_boundary,
    input  wire logic        trap_exec,
    input  wire logic        return_from_handler_instr,
    input  wire logic        mask_set,
    input  wire logic        mask_clr,
    input  wire logic        wait_mode,
    input  wire logic        halt_mode,
    input  wire logic [15:0] pc_in,
    input  wire logic [7:0]  x_in,
    input  wire logic [7:0]  a_in,
    input  wire logic [7:0]  cond_in,
    input  wire logic [15:0] sp_in,
    output logic             core_hold,
    output logic             global_mask,
    output logic             pc_load,
    output logic             ctx_load,
    output logic [15:0]      pc_out,
    output logic [7:0]       x_out,
    output logic [7:0]       a_out,
    output logic [7:0]       condition_code_register,
    output logic [15:0]      sp_out,
    output logic             wake,
    // memory port
    output logic [15:0]      mem_addr,
    output logic [7:0]       mem_wdata,
    output logic             mem_we,
    output logic             mem_re,
    input  wire logic [7:0]  mem_rdata
);
    vintu_pkg::vintu_regs_type r_r;
    vintu_pkg::vintu_regs_type r_nxt;
    logic [3:0]  ereq;
    logic [11:0] req;
    logic [3:0]  sel;
    logic [5:0]  spo;

    // line requests: level code also asserts while low
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            ereq[i] = (r_r.edge_l[i] | (r_r.sens[2*i +: 2] == vintu_pkg::S_LOWFALL
                      & ~ext_line[i])) & ~ext_nand_low[i];
        end
        req = {r_r.pflag & r_r.pen, 2'b00, ereq};
        sel = 4'h0;
        for (int j = vintu_pkg::NVEC; j >= 1; j--) begin
            if (req[j-1]) begin
                sel = 4'(j);
            end
        end
    end

    // stack slot offset for the current step, wraps in 64 bytes
    always_comb begin
        if (r_r.st == vintu_pkg::SEQ_POP) begin
            spo = r_r.sp[5:0] + 6'h01 + {3'h0, r_r.cnt};
        end else begin
            spo = r_r.sp[5:0] - {3'h0, r_r.cnt};
        end
    end

    // memory strobes follow the registered sequencer state
    always_comb begin
        mem_we    = (r_r.st == vintu_pkg::SEQ_PUSH);
        mem_re    = (r_r.st == vintu_pkg::SEQ_VHI) | (r_r.st == vintu_pkg::SEQ_VLO)
                    | (r_r.st == vintu_pkg::SEQ_POP);
        mem_addr  = vintu_pkg::STACK_BASE | {10'h000, spo};
        mem_wdata = 8'h00;
        if (r_r.st == vintu_pkg::SEQ_VHI) begin
            mem_addr = r_r.vaddr;
        end else if (r_r.st == vintu_pkg::SEQ_VLO) begin
            mem_addr = r_r.vaddr + 16'h0001;
        end
        unique case (r_r.cnt)
            3'h0: mem_wdata = r_r.pc[7:0];
            3'h1: mem_wdata = r_r.pc[15:8];
            3'h2: mem_wdata = r_r.x;
            3'h3: mem_wdata = r_r.a;
            default: mem_wdata = r_r.cond;
        endcase
    end

    // next state of the whole unit
    always_comb begin
        logic [3:0] fall;
        logic [3:0] rise;
        logic [3:0] ev;
        logic [2:0] item;
        logic       take;
        r_nxt        = r_r;
        fall         = r_r.pin_d & ~ext_line;
        rise         = ~r_r.pin_d & ext_line;
        ev           = 4'h0;
        item         = r_r.cnt - 3'h1;
        take         = 1'b0;
        r_nxt.pin_d  = ext_line;
        r_nxt.pc_ld  = 1'b0;
        r_nxt.ctx_ld = 1'b0;
        r_nxt.rdata  = 8'h00;
        // line edge detection by code
        for (int i = 0; i < 4; i++) begin
            unique case (r_r.sens[2*i +: 2])
                vintu_pkg::S_RISE: ev[i] = rise[i];
                vintu_pkg::S_BOTH: ev[i] = rise[i] | fall[i];
                default:           ev[i] = fall[i];
            endcase
        end
        // software mask control from the core
        if (mask_set) begin
            r_nxt.mask = 1'b1;
        end else if (mask_clr) begin
            r_nxt.mask = 1'b0;
        end
        // register writes; sensitivity only while masked
        if (reg_wr) begin
            unique case (reg_addr)
                vintu_pkg::A_SENS: begin
                    if (r_r.mask) begin
                        r_nxt.sens = reg_wdata;
                        for (int i = 0; i < 4; i++) begin
                            if (reg_wdata[2*i +: 2] != r_r.sens[2*i +: 2]) begin
                                r_nxt.edge_l[i] = 1'b0;
                            end
                        end
                    end
                end
                vintu_pkg::A_PEN:   r_nxt.pen = reg_wdata[5:0];
                vintu_pkg::A_PFLAG: r_nxt.pflag = r_r.pflag & reg_wdata[5:0];
                default: ;
            endcase
        end
        // reads; a flag seen set arms the second half of the sequence
        if (reg_rd) begin
            unique case (reg_addr)
                vintu_pkg::A_SENS:  r_nxt.rdata = r_r.sens;
                vintu_pkg::A_PEN:   r_nxt.rdata = {2'b00, r_r.pen};
                vintu_pkg::A_PFLAG: begin
                    r_nxt.rdata = {2'b00, r_r.pflag};
                    r_nxt.parm  = r_r.pflag;
                end
                vintu_pkg::A_PACK:  r_nxt.rdata = {r_r.mask, 3'h0, r_r.vec_n};
                vintu_pkg::A_EPEND: r_nxt.rdata = {4'h0, ereq};
                default:            r_nxt.rdata = 8'h00;
            endcase
        end
        // associated register access completes the clearing sequence
        if ((reg_rd | reg_wr) & (reg_addr == vintu_pkg::A_PACK)) begin
            r_nxt.pflag = r_nxt.pflag & ~r_r.parm;
            r_nxt.parm  = 6'h00;
        end
        if (return_from_handler_instr == 1'b0 && trap_exec) begin
            r_nxt.trap_pend = 1'b1;
        end
        // sequencer
        unique case (r_r.st)
            vintu_pkg::SEQ_IDLE: begin
                if (r_r.rst_pend) begin
                    r_nxt.rst_pend = 1'b0;
                    r_nxt.vaddr    = vintu_pkg::VEC_RESET;
                    r_nxt.vec_n    = 4'h0;
                    r_nxt.st       = vintu_pkg::SEQ_VHI;
                end else if (return_from_handler_instr) begin
                    r_nxt.sp  = sp_in;
                    r_nxt.cnt = 3'h0;
                    r_nxt.st  = vintu_pkg::SEQ_POP;
                end else if (instr_boundary & (r_r.trap_pend
                             | (~r_r.mask & (sel != 4'h0)))) begin
                    take       = 1'b1;
                    r_nxt.pc   = pc_in;
                    r_nxt.x    = x_in;
                    r_nxt.a    = a_in;
                    r_nxt.cond = cond_in;
                    r_nxt.cond[vintu_pkg::IBIT] = r_r.mask;
                    r_nxt.sp   = sp_in;
                    r_nxt.cnt  = 3'h0;
                    r_nxt.st   = vintu_pkg::SEQ_PUSH;
                    if (r_r.trap_pend) begin
                        r_nxt.trap_pend = 1'b0;
                        r_nxt.vaddr     = vintu_pkg::VEC_TRAP;
                        r_nxt.vec_n     = 4'h0;
                    end else begin
                        r_nxt.vaddr = vintu_pkg::VEC_BASE - {11'h000, sel, 1'b0};
                        r_nxt.vec_n = sel;
                        if (sel <= 4'h4) begin
                            r_nxt.edge_l[sel[1:0] - 2'h1] = 1'b0;
                        end
                    end
                end
            end
            vintu_pkg::SEQ_PUSH: begin
                r_nxt.cnt = r_r.cnt + 3'h1;
                if (r_r.cnt == vintu_pkg::CTX_LAST) begin
                    r_nxt.mask = 1'b1;
                    r_nxt.sp   = {r_r.sp[15:6], r_r.sp[5:0] - vintu_pkg::CTX_BYTES};
                    r_nxt.st   = vintu_pkg::SEQ_VHI;
                end
            end
            vintu_pkg::SEQ_VHI: r_nxt.st = vintu_pkg::SEQ_VLO;
            vintu_pkg::SEQ_VLO: begin
                r_nxt.pc[15:8] = mem_rdata;
                r_nxt.st       = vintu_pkg::SEQ_LDPC;
            end
            vintu_pkg::SEQ_LDPC: begin
                r_nxt.pc[7:0] = mem_rdata;
                r_nxt.pc_ld   = 1'b1;
                r_nxt.st      = vintu_pkg::SEQ_IDLE;
            end
            vintu_pkg::SEQ_POP, vintu_pkg::SEQ_POPL: begin
                if (r_r.st == vintu_pkg::SEQ_POPL) begin
                    item = vintu_pkg::CTX_LAST;
                end
                if (r_r.cnt != 3'h0 || r_r.st == vintu_pkg::SEQ_POPL) begin
                    unique case (item)
                        3'h0: r_nxt.cond = mem_rdata;
                        3'h1: r_nxt.a = mem_rdata;
                        3'h2: r_nxt.x = mem_rdata;
                        3'h3: r_nxt.pc[15:8] = mem_rdata;
                        default: r_nxt.pc[7:0] = mem_rdata;
                    endcase
                end
                r_nxt.cnt = r_r.cnt + 3'h1;
                if (r_r.st == vintu_pkg::SEQ_POPL) begin
                    r_nxt.cond[vintu_pkg::IBIT] = 1'b0;
                    r_nxt.mask   = 1'b0;
                    r_nxt.sp     = {r_r.sp[15:6], r_r.sp[5:0] + vintu_pkg::CTX_BYTES};
                    r_nxt.ctx_ld = 1'b1;
                    r_nxt.st     = vintu_pkg::SEQ_IDLE;
                end else if (r_r.cnt == vintu_pkg::CTX_LAST) begin
                    r_nxt.st = vintu_pkg::SEQ_POPL;
                end
            end
            default: r_nxt.st = vintu_pkg::SEQ_IDLE;
        endcase
        // new events win over any clear in the same cycle
        r_nxt.edge_l = r_nxt.edge_l | ev;
        r_nxt.pflag  = r_nxt.pflag | periph_evt;
        // wake: any request for wait, listed ones for halt
        r_nxt.wake = (wait_mode & ((|req) | r_r.trap_pend))
                     | (halt_mode & (|({req, 1'b0} & vintu_pkg::HALT_WAKE)));
        if (take) begin
            r_nxt.wake = 1'b0;
        end
    end

    // single state register, synchronous reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r_r          <= '0;
            r_r.st       <= vintu_pkg::SEQ_IDLE;
            r_r.mask     <= 1'b1;
            r_r.rst_pend <= 1'b1;
            r_r.sp       <= vintu_pkg::SP_RESET;
            r_r.sens     <= vintu_pkg::SENS_RST;
            r_r.pen      <= vintu_pkg::PEN_RST;
            r_r.pin_d    <= 4'hF;
        end else begin
            r_r <= r_nxt;
        end
    end

    // outputs
    assign reg_rdata   = r_r.rdata;
    assign core_hold   = (r_r.st != vintu_pkg::SEQ_IDLE) | r_r.rst_pend;
    assign global_mask = r_r.mask;
    assign pc_load     = r_r.pc_ld;
    assign ctx_load    = r_r.ctx_ld;
    assign pc_out      = r_r.pc;
    assign x_out       = r_r.x;
    assign a_out       = r_r.a;
    assign condition_code_register = r_r.cond;
    assign sp_out      = r_r.sp;
    assign wake        = r_r.wake;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_push5;
        mem_we [*5] ##1 (r_r.st == vintu_pkg::SEQ_VHI);
    endsequence
    sequence s_vfetch;
        (mem_re && mem_addr == r_r.vaddr) ##1 mem_re ##1 1'b1 ##1 pc_load;
    endsequence

    property p_rst_mask;
        $past(sys_rst) |-> global_mask && core_hold;
    endproperty
    a_rst_mask: assert property (p_rst_mask) else $error("mask clear after reset");
    property p_entry;
        $rose(mem_we) |-> $past(instr_boundary) ##0 s_push5 ##0 global_mask;
    endproperty
    a_entry: assert property (p_entry) else $error("bad entry sequence");
    property p_vec;
        (r_r.st == vintu_pkg::SEQ_VHI) |-> s_vfetch;
    endproperty
    a_vec: assert property (p_vec) else $error("vector fetch broken");
    property p_ret;
        $rose(r_r.st == vintu_pkg::SEQ_POP) |-> ##6 ctx_load && !global_mask
            && !condition_code_register[vintu_pkg::IBIT];
    endproperty
    a_ret: assert property (p_ret) else $error("return did not restore");
    property p_prio;
        (r_r.st == vintu_pkg::SEQ_IDLE && !r_r.rst_pend && instr_boundary
            && !return_from_handler_instr && !r_r.trap_pend && !global_mask && req[0])
            |=> r_r.vaddr == 16'hFFF8;
    endproperty
    a_prio: assert property (p_prio) else $error("line zero not chosen");
    property p_trap;
        (r_r.st == vintu_pkg::SEQ_IDLE && !r_r.rst_pend && instr_boundary
            && !return_from_handler_instr && r_r.trap_pend)
            |=> r_r.vaddr == vintu_pkg::VEC_TRAP ##4 mem_we;
    endproperty
    a_trap: assert property (p_trap) else $error("trap not taken");
    property p_halt;
        (halt_mode && !wait_mode && (req[6] || req[7] || req[9]) && req[3:0] == 4'h0
            && req[8] == 1'b0 && req[11:10] == 2'b00 && !r_r.trap_pend) |=> !wake;
    endproperty
    a_halt: assert property (p_halt) else $error("halt ended by wrong source");
    property p_held;
        (global_mask && !r_r.trap_pend && r_r.st == vintu_pkg::SEQ_IDLE && !r_r.rst_pend)
            |=> !mem_we;
    endproperty
    a_held: assert property (p_held) else $error("masked request serviced");
    property p_waitw;
        (wait_mode && req != 12'h000) |=> wake || $past(instr_boundary);
    endproperty
    a_waitw: assert property (p_waitw) else $error("wait not ended");
endmodule

// ===== testbench/vintu_core_model.sv
/*
 partner model: core side of the interrupt unit, stack ram and vector rom.
 assumes memory read data are wanted one cycle after mem_re.
*/
module vintu_core_model (
    // clock and bench control
    input  wire logic        clk,
    input  wire logic        bnd_en,
    // core handshake
    input  wire logic        core_hold,
    output logic             instr_boundary,
    // memory port
    input  wire logic [15:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    input  wire logic        mem_we,
    input  wire logic        mem_re,
    output logic      [7:0]  mem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] ram [0:255];
    initial mem_rdata = 8'h00;
    // never offer a boundary while the unit stalls the core
    assign instr_boundary = bnd_en && !core_hold;
    // rom byte is the low address byte, so a vector reads back as {lo, lo+1}
    always @(posedge clk) begin
        if (mem_we && mem_addr[15:8] == 8'h00)
            ram[mem_addr[7:0]] <= mem_wdata;
        if (mem_re)
            mem_rdata <= (mem_addr[15:8] == 8'h00) ? ram[mem_addr[7:0]] : mem_addr[7:0];
        else
            mem_rdata <= ~mem_rdata; // no stale byte outside a read
    end
endmodule

// ===== testbench/test_vintu_top.sv
/*
 bench for the vectored interrupt unit: reset vector, trap, return,
 priority, flag clearing, external lines and wake-up.
 assumes the core model answers memory reads and gates the boundary.
*/
module test_vintu_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, sys_rst, reg_wr, reg_rd, bnd_en, instr_boundary;
    logic [2:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, x_in, a_in, cond_in, rv;
    logic [3:0]  ext_line, ext_nand_low;
    logic [5:0]  periph_evt;
    logic        trap_exec, ret_instr, mask_set, mask_clr, wait_mode, halt_mode;
    logic [15:0] pc_in, sp_in, pc_out, sp_out, mem_addr;
    logic        core_hold, global_mask, pc_load, ctx_load, wake, mem_we, mem_re;
    logic [7:0]  x_out, a_out, cond_out, mem_wdata, mem_rdata;
    logic [7:0]  stk [0:4] = '{8'h34, 8'h12, 8'h56, 8'h78, 8'h09};
    int          bad_count, checks_done;

    vintu_top u_vintu_top (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_line(ext_line),
        .ext_nand_low(ext_nand_low), .periph_evt(periph_evt),
        .instr_boundary(instr_boundary), .trap_exec(trap_exec),
        .return_from_handler_instr(ret_instr), .mask_set(mask_set), .mask_clr(mask_clr),
        .wait_mode(wait_mode), .halt_mode(halt_mode), .pc_in(pc_in), .x_in(x_in),
        .a_in(a_in), .cond_in(cond_in), .sp_in(sp_in), .core_hold(core_hold),
        .global_mask(global_mask), .pc_load(pc_load), .ctx_load(ctx_load),
        .pc_out(pc_out), .x_out(x_out), .a_out(a_out), .condition_code_register(cond_out),
        .sp_out(sp_out), .wake(wake), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata)
    );
    vintu_core_model u_vintu_core_model (
        .clk(clk), .bnd_en(bnd_en), .core_hold(core_hold),
        .instr_boundary(instr_boundary), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata)
    );

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        end_of_test();
    end

    task automatic end_of_test();
        if (bad_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
            bad_count++;
        end
    endtask
    // register port: one-cycle strobes, read data in the following cycle only
    task automatic wr(input logic [2:0] ad, input logic [7:0] d);
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr} <= {ad, d, 1'b1};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] ad);
        @(posedge clk);
        {reg_addr, reg_rd} <= {ad, 1'b1};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    // core pulses: 0 trap, 1 return, 2 mask set, 3 mask clear, else events in k[9:4]
    task automatic pulse(input int k);
        @(posedge clk);
        case (k)
            0: trap_exec <= 1'b1;
            1: ret_instr <= 1'b1;
            2: mask_set <= 1'b1;
            3: mask_clr <= 1'b1;
            default: periph_evt <= k[9:4];
        endcase
        @(posedge clk);
        {trap_exec, ret_instr, mask_set, mask_clr, periph_evt} <= '0;
    endtask
    // bounded wait for the pc load, then the vector read back big endian
    task automatic entry(input logic [15:0] vec);
        for (int i = 0; i < 40 && pc_load !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk("pc_load", 16'(pc_load), 16'h0001);
        chk("pc_out", pc_out, {vec[7:0], vec[7:0] + 8'h01});
    endtask
    task automatic quiet(input int n);
        int hits;
        hits = 0;
        repeat (n) begin
            @(posedge clk);
            #1 hits += int'(pc_load);
        end
        chk("no entry", hits[15:0], 16'h0000);
    endtask
    // every return pops the trap context stacked at 00FBh..00FFh
    task automatic ret();
        pulse(1);
        for (int i = 0; i < 20 && ctx_load !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk("ret pc", pc_out, 16'h1234);
        chk("ret x a", {x_out, a_out}, 16'h5678);
        chk("ret cond", 16'(cond_out), 16'h0001);
        chk("ret mask", 16'(global_mask), 16'h0000);
        chk("ret sp", sp_out, 16'h00FF);
    endtask

    initial begin
        bad_count = 0;
        checks_done = 0;
        {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata, bnd_en} = {1'b1, 14'h0000};
        {ext_line, ext_nand_low, periph_evt} = {4'hF, 10'h000};
        {trap_exec, ret_instr, mask_set, mask_clr, wait_mode, halt_mode} = '0;
        {pc_in, x_in, a_in, cond_in, sp_in} = {16'h1234, 8'h56, 8'h78, 8'h01, 16'h00FF};
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        #1 chk("reset mask", 16'(global_mask), 16'h0001);
        entry(vintu_pkg::VEC_RESET);
        rd(vintu_pkg::A_SENS);
        chk("sens reset", 16'(rv), 16'(vintu_pkg::SENS_RST));
        rd(vintu_pkg::A_PEN);
        chk("pen reset", 16'(rv), 16'(vintu_pkg::PEN_RST));
        rd(3'h7);
        chk("unmapped", 16'(rv), 16'h0000);
        // trap with the mask still set from reset
        @(posedge clk) bnd_en <= 1'b1;
        pulse(0);
        entry(vintu_pkg::VEC_TRAP);
        for (int k = 0; k < 5; k++)
            chk("stack", 16'(u_vintu_core_model.ram[8'hFF - k[7:0]]), 16'(stk[k]));
        chk("entry sp", sp_out, 16'h00FA);
        chk("entry mask", 16'(global_mask), 16'h0001);
        @(posedge clk) sp_in <= 16'h00FA;
        ret();
        // two enabled flags held while masked, then priority and nesting
        pulse(2);
        wr(vintu_pkg::A_PEN, 8'h21);
        pulse(32'h0000_0210);
        quiet(20);
        @(posedge clk) bnd_en <= 1'b0;
        pulse(3);
        quiet(10);
        @(posedge clk) bnd_en <= 1'b1;
        entry(vintu_pkg::VEC_BASE - 16'h000E);
        wr(vintu_pkg::A_PFLAG, 8'h20);
        pulse(3);
        entry(vintu_pkg::VEC_BASE - 16'h0018);
        wr(vintu_pkg::A_PFLAG, 8'h00);
        ret();
        ret();
        // disabled flag discarded by the clearing sequence
        pulse(2);
        wr(vintu_pkg::A_PEN, 8'h00);
        pulse(32'h0000_0100);
        rd(vintu_pkg::A_PFLAG);
        chk("flag set", 16'(rv), 16'h0010);
        rd(vintu_pkg::A_PACK);
        chk("ack mask vec", 16'(rv), 16'h008C);
        rd(vintu_pkg::A_PFLAG);
        chk("flag cleared", 16'(rv), 16'h0000);
        wr(vintu_pkg::A_PEN, 8'h10);
        pulse(3);
        quiet(20);
        // wake-up from halt and wait
        pulse(2);
        wr(vintu_pkg::A_PEN, 8'h05);
        @(posedge clk) halt_mode <= 1'b1;
        pulse(32'h0000_0010);
        repeat (3) @(posedge clk);
        #1 chk("halt wake warn", 16'(wake), 16'h0000);
        pulse(32'h0000_0040);
        repeat (2) @(posedge clk);
        #1 chk("halt wake ovf", 16'(wake), 16'h0001);
        @(posedge clk) {halt_mode, wait_mode} <= 2'b01;
        wr(vintu_pkg::A_PFLAG, 8'h01);
        repeat (2) @(posedge clk);
        #1 chk("wait wake", 16'(wake), 16'h0001);
        wr(vintu_pkg::A_PFLAG, 8'h00);
        repeat (2) @(posedge clk);
        #1 chk("wake idle", 16'(wake), 16'h0000);
        @(posedge clk) wait_mode <= 1'b0;
        // external lines: rising edges, one line held by a low combined pin
        @(posedge clk) ext_nand_low <= 4'h2;
        wr(vintu_pkg::A_SENS, 8'h05);
        @(posedge clk) ext_line <= 4'hC;
        @(posedge clk) ext_line <= 4'hF;
        rd(vintu_pkg::A_EPEND);
        chk("line0 latched", 16'(rv[0]), 16'h0001);
        wr(vintu_pkg::A_SENS, 8'h06);
        rd(vintu_pkg::A_EPEND);
        chk("code change", 16'(rv[0]), 16'h0000);
        wr(vintu_pkg::A_SENS, 8'h05);
        @(posedge clk) ext_line <= 4'hE;
        @(posedge clk) ext_line <= 4'hF;
        pulse(3);
        entry(vintu_pkg::VEC_BASE - 16'h0002);
        rd(vintu_pkg::A_EPEND);
        chk("line0 served", 16'(rv[0]), 16'h0000);
        ret();
        quiet(20);
        end_of_test();
    end
endmodule
